// ---- include/reset_cause_pkg.sv ----
// constants, types and cause decoding for the reset cause and init state block
package reset_cause_pkg;

  // ****************************************
  // widths and register offsets
  // ****************************************
  localparam int DATA_W = 8;
  localparam int ADDR_W = 4;
  localparam int PC_W = 13;
  localparam logic [3:0] STATUS_OFS = 4'h0;
  localparam logic [3:0] POWER_CONTROL_REG_OFS = 4'h1;
  localparam logic [3:0] OPTION_OFS = 4'h2;
  localparam logic [3:0] DIR_OFS = 4'h3;
  localparam logic [3:0] IRQCTL_OFS = 4'h4;
  localparam logic [3:0] PIRA_OFS = 4'h5;
  localparam logic [3:0] PIRB_OFS = 4'h6;
  localparam logic [3:0] EVT_STAT_OFS = 4'h7;
  localparam logic [3:0] EVT_MASK_OFS = 4'h8;
  localparam logic [3:0] CAUSE_OFS = 4'h9;

  // ****************************************
  // field positions, masks, reset values
  // ****************************************
  localparam int STATUS_TO_BIT = 4;
  localparam int STATUS_PD_BIT = 3;
  localparam int POWER_CONTROL_REG_POR_BIT = 1;
  localparam int POWER_CONTROL_REG_BOR_BIT = 0;
  localparam int IRQCTL_GIE_BIT = 7;
  localparam logic [7:0] STATUS_RST = 8'h18;
  localparam logic [7:0] POWER_CONTROL_REG_IMPL = 8'h03;
  localparam logic [7:0] POWER_CONTROL_REG_RST = 8'h00;
  localparam logic [7:0] OPTION_RST = 8'hFF;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] IRQCTL_RST = 8'h00;
  localparam logic [7:0] IRQCTL_KEEP = 8'h01;
  localparam logic [7:0] PIRA_IMPL = 8'h77;
  localparam logic [7:0] PIRB_IMPL = 8'h01;
  localparam logic [7:0] PIR_RST = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_IRQ_VEC = 13'h0004;
  localparam logic [1:0] GRP_IRQCTL = 2'h0;
  localparam logic [1:0] GRP_PIRA = 2'h1;
  localparam logic [1:0] GRP_PIRB = 2'h2;

  // event bits of the interrupt status and mask registers
  localparam int EVT_W = 6;
  localparam int EVT_POR = 0;
  localparam int EVT_BOR = 1;
  localparam int EVT_WDT_RST = 2;
  localparam int EVT_WDT_WAKE = 3;
  localparam int EVT_PIN = 4;
  localparam int EVT_IRQ_WAKE = 5;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [7:0] {
    C_NONE = 8'b0000_0001,
    C_POR = 8'b0000_0010,
    C_BOR = 8'b0000_0100,
    C_WDT_RST = 8'b0000_1000,
    C_WDT_WAKE = 8'b0001_0000,
    C_PIN_RUN = 8'b0010_0000,
    C_PIN_SLEEP = 8'b0100_0000,
    C_IRQ_WAKE = 8'b1000_0000
  } cause_t;

  typedef struct packed {
    logic por;
    logic bor;
    logic wdt;
    logic pin;
    logic irq_wake;
  } reset_src_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic valid;
    logic [12:0] addr;
  } pc_load_t;

  function automatic cause_t decode_cause(input reset_src_t src, input logic sleeping);
    cause_t c;
    c = C_NONE;
    if (src.por) begin
      c = C_POR;
    end else if (src.bor) begin
      c = C_BOR;
    end else if (src.wdt) begin
      c = sleeping ? C_WDT_WAKE : C_WDT_RST;
    end else if (src.pin) begin
      c = sleeping ? C_PIN_SLEEP : C_PIN_RUN;
    end else if (src.irq_wake && sleeping) begin
      c = C_IRQ_WAKE;
    end
    return c;
  endfunction : decode_cause

endpackage : reset_cause_pkg

// ---- logic/reset_cause_and_init_state.sv ----
// reset cause flags, initial register state and restart address
//
// The implementer's own choices: the address-and-strobe port and the placing of the registers.
module reset_cause_and_init_state
  import reset_cause_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire reset_src_t src,
  input wire logic sleeping,
  input wire logic [12:0] sleep_pc,
  input wire logic [4:0] wake_flag_sel,
  input wire reg_req_t req,
  output logic [7:0] rdata,
  output pc_load_t pc_load,
  output cause_t cause_out,
  output logic [7:0] option_out,
  output logic [7:0] direction_out,
  output logic gie_out,
  output logic irq_out
);

  // ****************************************
  // cause decode and reset classes
  // ****************************************
  cause_t cause;
  logic full_rst;
  logic warm_rst;
  logic wake;
  logic wr_status;
  logic wr_power_control_reg;
  logic wr_option;
  logic wr_dir;
  logic wr_irqctl;
  logic wr_pira;
  logic wr_pirb;
  logic wr_evt_stat;
  logic wr_evt_mask;
  logic [7:0] wake_flag_bit;
  logic [1:0] wake_grp;

  logic [7:0] status_reg;
  logic [7:0] power_control_reg_reg;
  logic [7:0] option_reg;
  logic [7:0] dir_reg;
  logic [7:0] irqctl_reg;
  logic [7:0] pira_reg;
  logic [7:0] pirb_reg;
  logic [EVT_W-1:0] evt_stat_reg;
  logic [EVT_W-1:0] evt_mask_reg;
  logic [EVT_W-1:0] evt_hit;
  logic to_next;
  logic pd_next;

  always_comb begin
    cause = decode_cause(src, sleeping);
  end

  assign full_rst = (cause == C_POR) || (cause == C_BOR);
  assign warm_rst = (cause == C_WDT_RST) || (cause == C_PIN_RUN) || (cause == C_PIN_SLEEP);
  assign wake = (cause == C_WDT_WAKE) || (cause == C_IRQ_WAKE);

  assign wr_status = req.wr && (req.addr == STATUS_OFS);
  assign wr_power_control_reg = req.wr && (req.addr == POWER_CONTROL_REG_OFS);
  assign wr_option = req.wr && (req.addr == OPTION_OFS);
  assign wr_dir = req.wr && (req.addr == DIR_OFS);
  assign wr_irqctl = req.wr && (req.addr == IRQCTL_OFS);
  assign wr_pira = req.wr && (req.addr == PIRA_OFS);
  assign wr_pirb = req.wr && (req.addr == PIRB_OFS);
  assign wr_evt_stat = req.wr && (req.addr == EVT_STAT_OFS);
  assign wr_evt_mask = req.wr && (req.addr == EVT_MASK_OFS);

  // only an interrupt wake names a flag; a watchdog wake has none here
  assign wake_grp = wake_flag_sel[4:3];
  assign wake_flag_bit = (cause == C_IRQ_WAKE) ? (8'h01 << wake_flag_sel[2:0]) : 8'h00;

  // ****************************************
  // timeout and powerdown values
  // ****************************************
  always_comb begin
    to_next = status_reg[STATUS_TO_BIT];
    pd_next = status_reg[STATUS_PD_BIT];
    unique case (cause)
      C_POR: begin
        to_next = 1'b1;
        pd_next = 1'b1;
      end
      C_BOR: begin
        to_next = 1'b1;
        pd_next = 1'b1;
      end
      C_WDT_RST: begin
        to_next = 1'b0;
        pd_next = 1'b1;
      end
      C_WDT_WAKE: begin
        to_next = 1'b0;
        pd_next = 1'b0;
      end
      C_PIN_RUN: begin
        to_next = status_reg[STATUS_TO_BIT];
        pd_next = status_reg[STATUS_PD_BIT];
      end
      C_PIN_SLEEP: begin
        to_next = 1'b1;
        pd_next = 1'b0;
      end
      C_IRQ_WAKE: begin
        to_next = 1'b1;
        pd_next = 1'b0;
      end
      C_NONE: begin
        to_next = status_reg[STATUS_TO_BIT];
        pd_next = status_reg[STATUS_PD_BIT];
      end
    endcase
    // no illegal pair
    // while the power-on flag is still clear, keep both set
    if (!power_control_reg_reg[POWER_CONTROL_REG_POR_BIT] || (cause == C_POR)) begin
      to_next = 1'b1;
      pd_next = 1'b1;
    end
  end

  // ****************************************
  // status register
  // ****************************************
  // cause-dependent status bits
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_reg <= STATUS_RST;
    end else if (full_rst || warm_rst) begin
      status_reg <= {3'b000, to_next, pd_next, status_reg[2:0]};
    end else if (wake) begin
      status_reg <= {status_reg[7:5], to_next, pd_next, status_reg[2:0]};
    end else if (wr_status) begin
      // timeout and powerdown are not software writable
      status_reg <= {req.wdata[7:5], status_reg[4:3], req.wdata[2:0]};
    end
  end

  // ****************************************
  // power control register
  // ****************************************
  // only power-on and brown-out resets and writes touch it
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      power_control_reg_reg <= POWER_CONTROL_REG_RST;
    end else if (cause == C_POR) begin
      power_control_reg_reg[POWER_CONTROL_REG_POR_BIT] <= 1'b0;
    end else if (cause == C_BOR) begin
      power_control_reg_reg[POWER_CONTROL_REG_BOR_BIT] <= 1'b0;
    end else if (wr_power_control_reg) begin
      power_control_reg_reg <= req.wdata & POWER_CONTROL_REG_IMPL;
    end
  end

  // ****************************************
  // option and direction registers
  // ****************************************
  // reset to all ones
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      option_reg <= OPTION_RST;
    end else if (full_rst || warm_rst) begin
      option_reg <= OPTION_RST;
    end else if (wr_option) begin
      option_reg <= req.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_reg <= DIR_RST;
    end else if (full_rst || warm_rst) begin
      dir_reg <= DIR_RST;
    end else if (wr_dir) begin
      dir_reg <= req.wdata;
    end
  end

  // ****************************************
  // interrupt flag registers
  // ****************************************
  // a wake flag in the same cycle as a write wins over the write
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqctl_reg <= IRQCTL_RST;
    end else if (full_rst) begin
      irqctl_reg <= IRQCTL_RST;
    end else if (warm_rst) begin
      irqctl_reg <= irqctl_reg & IRQCTL_KEEP;
    end else if (wake_grp == GRP_IRQCTL) begin
      irqctl_reg <= (wr_irqctl ? req.wdata : irqctl_reg) | wake_flag_bit;
    end else if (wr_irqctl) begin
      irqctl_reg <= req.wdata;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pira_reg <= PIR_RST;
    end else if (full_rst || warm_rst) begin
      pira_reg <= PIR_RST;
    end else begin
      pira_reg <= ((wr_pira ? req.wdata : pira_reg)
                   | ((wake_grp == GRP_PIRA) ? wake_flag_bit : 8'h00)) & PIRA_IMPL;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pirb_reg <= PIR_RST;
    end else if (full_rst || warm_rst) begin
      pirb_reg <= PIR_RST;
    end else begin
      pirb_reg <= ((wr_pirb ? req.wdata : pirb_reg)
                   | ((wake_grp == GRP_PIRB) ? wake_flag_bit : 8'h00)) & PIRB_IMPL;
    end
  end

  // ****************************************
  // restart address
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_load <= '{valid: 1'b1, addr: PC_RESET};
    end else if (full_rst || warm_rst) begin
      pc_load <= '{valid: 1'b1, addr: PC_RESET};
    end else if ((cause == C_IRQ_WAKE) && irqctl_reg[IRQCTL_GIE_BIT]) begin
      pc_load <= '{valid: 1'b1, addr: PC_IRQ_VEC};
    end else if (wake) begin
      pc_load <= '{valid: 1'b1, addr: 13'(sleep_pc + 13'h0001)};
    end else begin
      pc_load <= '{valid: 1'b0, addr: pc_load.addr};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cause_out <= C_POR;
    end else if (cause != C_NONE) begin
      cause_out <= cause;
    end
  end

  // ****************************************
  // event status, mask and interrupt
  // ****************************************
  assign evt_hit[EVT_POR] = (cause == C_POR);
  assign evt_hit[EVT_BOR] = (cause == C_BOR);
  assign evt_hit[EVT_WDT_RST] = (cause == C_WDT_RST);
  assign evt_hit[EVT_WDT_WAKE] = (cause == C_WDT_WAKE);
  assign evt_hit[EVT_PIN] = (cause == C_PIN_RUN) || (cause == C_PIN_SLEEP);
  assign evt_hit[EVT_IRQ_WAKE] = (cause == C_IRQ_WAKE);

  // set beats a write-one-to-clear in the same cycle
  for (genvar i = 0; i < EVT_W; i++) begin : g_evt
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        evt_stat_reg[i] <= 1'b0;
      end else if (evt_hit[i]) begin
        evt_stat_reg[i] <= 1'b1;
      end else if (wr_evt_stat && req.wdata[i]) begin
        evt_stat_reg[i] <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      evt_mask_reg <= '0;
    end else if (wr_evt_mask) begin
      evt_mask_reg <= req.wdata[EVT_W-1:0];
    end
  end

  // registered, so it trails the status bit by one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(evt_stat_reg & evt_mask_reg);
    end
  end

  // ****************************************
  // register read and plain outputs
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      unique case (req.addr)
        STATUS_OFS: rdata <= status_reg;
        POWER_CONTROL_REG_OFS: rdata <= power_control_reg_reg & POWER_CONTROL_REG_IMPL;
        OPTION_OFS: rdata <= option_reg;
        DIR_OFS: rdata <= dir_reg;
        IRQCTL_OFS: rdata <= irqctl_reg;
        PIRA_OFS: rdata <= pira_reg;
        PIRB_OFS: rdata <= pirb_reg;
        EVT_STAT_OFS: rdata <= {2'b00, evt_stat_reg};
        EVT_MASK_OFS: rdata <= {2'b00, evt_mask_reg};
        CAUSE_OFS: rdata <= cause_out;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      option_out <= OPTION_RST;
      direction_out <= DIR_RST;
      gie_out <= 1'b0;
    end else begin
      option_out <= option_reg;
      direction_out <= dir_reg;
      gie_out <= irqctl_reg[IRQCTL_GIE_BIT];
    end
  end

endmodule : reset_cause_and_init_state

// ---- sim/reset_src_model.sv ----
// reset detector model: one-cycle source pulses on request
module reset_src_model
  import reset_cause_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic fire,
  input wire reset_src_t pend,
  output reset_src_t src
);
  timeunit 1ns;
  timeprecision 1ns;
  // pulse only, sources never held high
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      src <= '0;
    end else begin
      src <= fire ? pend : '0;
    end
  end
endmodule : reset_src_model

// ---- sim/reset_cause_monitor.sv ----
// checker of restart address, cause and read timing
module reset_cause_monitor
  import reset_cause_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire reset_src_t src,
  input wire logic sleeping,
  input wire logic [12:0] sleep_pc,
  input wire logic [4:0] wake_flag_sel,
  input wire reg_req_t req,
  input wire logic [7:0] rdata,
  input wire pc_load_t pc_load,
  input wire cause_t cause_out,
  input wire logic [7:0] option_out,
  input wire logic [7:0] direction_out,
  input wire logic gie_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);
  // ****
  // properties
  // ****
  property p_por_pc;
    src.por |=> pc_load.valid && pc_load.addr == PC_RESET && cause_out == C_POR;
  endproperty
  a_por_pc: assert property (p_por_pc) else $error("power-on restart wrong");
  property p_wdt_pc;
    src == 5'h04 && sleeping |=> pc_load.valid && pc_load.addr == $past(sleep_pc) + 13'h0001;
  endproperty
  a_wdt_pc: assert property (p_wdt_pc) else $error("watchdog wake address wrong");
  // gie_out lags the register, so quiet cycles only
  property p_irq_vec;
    src == 5'h01 && sleeping && gie_out && !$past(req.wr) && $past(src) == 5'h00 |=> pc_load.addr == PC_IRQ_VEC;
  endproperty
  a_irq_vec: assert property (p_irq_vec) else $error("vector not taken");
  property p_irq_seq;
    src == 5'h01 && sleeping && !gie_out && !$past(req.wr) && $past(src) == 5'h00
      |=> pc_load.addr == $past(sleep_pc) + 13'h0001;
  endproperty
  a_irq_seq: assert property (p_irq_seq) else $error("wake address wrong");
  property p_bor_cause;
    src.bor && !src.por |=> cause_out == C_BOR;
  endproperty
  a_bor_cause: assert property (p_bor_cause) else $error("brown-out cause wrong");
  property p_cause_hold;
    src == 5'h00 |=> $stable(cause_out);
  endproperty
  a_cause_hold: assert property (p_cause_hold) else $error("cause changed alone");
  property p_pc_pulse;
    pc_load.valid && src == 5'h00 |=> !pc_load.valid;
  endproperty
  a_pc_pulse: assert property (p_pc_pulse) else $error("restart pulse too long");
  property p_reset_ff;
    src.por || src.bor |=> ##1 option_out == OPTION_RST && direction_out == DIR_RST && !gie_out;
  endproperty
  a_reset_ff: assert property (p_reset_ff) else $error("init class wrong");
  property p_wake_keep;
    src == 5'h04 && sleeping && !req.wr |=> ##1 $stable(option_out) && $stable(direction_out);
  endproperty
  a_wake_keep: assert property (p_wake_keep) else $error("wake altered registers");
  property p_unmapped;
    req.rd && req.addr > CAUSE_OFS |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule : reset_cause_monitor

bind reset_cause_and_init_state reset_cause_monitor reset_cause_monitor_inst (
  .ref_clk(ref_clk), .rst_n(rst_n), .src(src), .sleeping(sleeping), .sleep_pc(sleep_pc),
  .wake_flag_sel(wake_flag_sel), .req(req), .rdata(rdata), .pc_load(pc_load), .cause_out(cause_out),
  .option_out(option_out), .direction_out(direction_out), .gie_out(gie_out), .irq_out(irq_out));

// ---- sim/reset_cause_and_init_state_tb.sv ----
// bench: register and restart model compared with the design
module reset_cause_and_init_state_tb
  import reset_cause_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  // flag pair per cause, -1 keeps; event bit; writable bits
  localparam int TP [7] = '{'h18, 'h18, 'h08, 'h00, -1, 'h10, 'h10};
  localparam int EV [7] = '{0, 1, 2, 3, 4, 4, 5};
  localparam int WM [9] = '{'hE7, 'h03, 'hFF, 'hFF, 'hFF, 'h77, 'h01, 0, 'h3F};
  localparam logic [4:0] PS [10] = '{5'h08, 5'h04, 5'h04, 5'h02, 5'h02, 5'h01, 5'h01, 5'h18, 5'h01, 5'h06};
  localparam logic [9:0] SL = 10'h274;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic sleeping = 1'b0;
  logic fire = 1'b0;
  logic [12:0] sleep_pc = 13'h0000;
  logic [4:0] wake_flag_sel = 5'h00;
  reset_src_t pend = '0;
  reset_src_t src;
  reg_req_t req = '0;
  logic [7:0] rdata;
  pc_load_t pc_load;
  cause_t cause_out;
  logic [7:0] option_out;
  logic [7:0] direction_out;
  logic gie_out;
  logic irq_out;
  int errors = 0;
  int num_checks = 0;
  int cycles = 0;
  int seed = 32'h8b72e7cc;
  int m [16];
  int i;
  int d;

  always #50 ref_clk = ~ref_clk;

  reset_src_model reset_src_model_inst (.ref_clk(ref_clk), .rst_n(rst_n), .fire(fire), .pend(pend), .src(src));
  reset_cause_and_init_state reset_cause_and_init_state_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .src(src), .sleeping(sleeping), .sleep_pc(sleep_pc),
    .wake_flag_sel(wake_flag_sel), .req(req), .rdata(rdata), .pc_load(pc_load), .cause_out(cause_out),
    .option_out(option_out), .direction_out(direction_out), .gie_out(gie_out), .irq_out(irq_out));

  // ****
  // tasks
  // ****
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
    @(posedge ref_clk);
    req <= '0;
    // one idle edge so the next call never reassigns req in this step
    @(posedge ref_clk);
    if (a == EVT_STAT_OFS) begin
      m[7] = m[7] & ~int'(v);
    end else if (a < CAUSE_OFS) begin
      m[a] = (m[a] & ~WM[a]) | (int'(v) & WM[a]);
    end
  endtask : wr

  task automatic rd(input logic [3:0] a);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge ref_clk);
    req <= '0;
    #1;
    chk(16'(rdata), 16'(m[a]));
    @(posedge ref_clk);
  endtask : rd

  task automatic check_all();
    for (int a = 0; a < 16; a++) begin
      rd(4'(a));
    end
    chk(16'(option_out), 16'(m[2]));
    chk(16'(direction_out), 16'(m[3]));
    chk(16'(gie_out), 16'(m[4][7]));
    chk(16'(irq_out), 16'((m[7] & m[8]) != 0));
  endtask : check_all

  task automatic hit(input logic [4:0] p, input logic slp, input logic [4:0] ws);
    int k;
    int tp;
    logic [12:0] pc;
    logic [12:0] epc;
    pc = 13'($random(seed));
    k = p[4] ? 0 : p[3] ? 1 : p[2] ? (slp ? 3 : 2) : p[1] ? (slp ? 5 : 4) : (slp ? 6 : 7);
    epc = (k == 6 && m[4][7]) ? PC_IRQ_VEC : (k == 3 || k == 6) ? pc + 13'h0001 : PC_RESET;
    sleep_pc <= pc;
    sleeping <= slp;
    wake_flag_sel <= ws;
    pend <= p;
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    @(posedge ref_clk);
    #1;
    if (k == 7) begin
      chk(16'(pc_load.valid), 16'h0000);
      return;
    end
    chk(16'(pc_load), 16'({1'b1, epc}));
    chk(16'(cause_out), 16'(2 << k));
    // flags forced high until software marks the power-on flag
    tp = ((m[1] & 2) == 0) ? 'h18 : (k == 4) ? (m[0] & 'h18) : TP[k];
    m[0] = (m[0] & ((k == 3 || k == 6) ? 'hE7 : 'h07)) | tp;
    m[1] = m[1] & ((k == 0) ? 1 : (k == 1) ? 2 : 3);
    if (k != 3 && k != 6) begin
      m[2] = 'hFF;
      m[3] = 'hFF;
      m[4] = (k < 2) ? 0 : (m[4] & 1);
      m[5] = 0;
      m[6] = 0;
    end
    if (k == 6) begin
      m[4 + ws[4:3]] = m[4 + ws[4:3]] | (1 << ws[2:0]);
    end
    m[7] = m[7] | (1 << EV[k]);
    m[9] = 2 << k;
  endtask : hit

  // ****
  // sequence
  // ****
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    m = '{'h18, 0, 'hFF, 'hFF, 0, 0, 0, 0, 0, 'h02, 0, 0, 0, 0, 0, 0};
    repeat (10) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    wr(EVT_STAT_OFS, 8'hFF);
    wr(EVT_MASK_OFS, 8'h00);
    check_all();
    for (i = 0; i < 10; i++) begin
      d = $random(seed);
      wr(POWER_CONTROL_REG_OFS, (i == 3) ? 8'h00 : 8'h03);
      wr(STATUS_OFS, 8'(d) & 8'hF8);
      wr(OPTION_OFS, 8'(d >> 8));
      wr(DIR_OFS, 8'(d >> 16));
      wr(IRQCTL_OFS, {i == 6, d[30:24]});
      wr(PIRA_OFS, 8'(d >> 4) & PIRA_IMPL);
      wr(EVT_STAT_OFS, 8'hFF);
      wr(EVT_MASK_OFS, 8'(d >> 12) & 8'h3F);
      hit(PS[i], SL[i], d[3] ? 5'h10 : {1'b0, d[2], 1'b0, d[0], 1'b0});
      check_all();
    end
    wr(EVT_MASK_OFS, 8'h3F);
    check_all();
    wr(EVT_STAT_OFS, 8'h3F);
    check_all();
    conclude();
  end
endmodule : reset_cause_and_init_state_tb
